// ===== inc/mssr_defs.svh
// Constants for the module sideband select and reset block
`ifndef MSSR_DEFS_SVH
`define MSSR_DEFS_SVH
`define MSSR_CLK_HZ 50000000
`define MSSR_POWERUP_MS 2000
`define MSSR_POWERUP_CYC ((`MSSR_POWERUP_MS * (`MSSR_CLK_HZ / 1000)))
`define MSSR_RST_MIN_CYC 500
`define MSSR_INIT_CYC 1000
`define MSSR_CNT_W 32
`endif

// ===== inc/mssr_pkg.sv
// Types for the module sideband select and reset block
package mssr_pkg;
  typedef enum logic [1:0] {
    MSSR_POWERUP,
    MSSR_RUN,
    MSSR_RESET,
    MSSR_INIT
  } mssr_state_e;
endpackage

// ===== logic/mssr_sync.sv
// Two-stage synchroniser for one pin level
`timescale 1ns/1ps
module mssr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset
  input wire logic pin_in, // Asynchronous level
  output logic sync_out // Synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule // mssr_sync

// ===== logic/mssr_top.sv
// Module-side select, reset, attention and presence control
// Notes on behaviour
// - Serial management commands are acted on only while select is low.
// - Select high: ignore bus traffic, never acknowledge nor drive data line.
// - Undriven select reads high, so module stays unselected.
// - Reset held low past minimum length in run state restores all user settings.
// - Initialisation interval starts when reset input rises.
// - Completion shown by attention low with data-not-ready cleared.
// - Power-up posts completion attention without any reset pulse.
// - Attention low also flags a fault or critical status; faults in reset or init are dropped.
// - Presence output is tied low while inserted.
// - Fully functional within 2000 ms of supply becoming valid.
`timescale 1ns/1ps
`include "mssr_defs.svh"
module mssr_top
  import mssr_pkg::*;
#(
  parameter int RST_MIN_CYC = `MSSR_RST_MIN_CYC,
  parameter int INIT_CYC = `MSSR_INIT_CYC,
  parameter int POWERUP_CYC = `MSSR_POWERUP_CYC
) (
  input wire logic CORE_CLK, // Core clock, 50 MHz
  input wire logic RST_N, // Power-on reset, synchronous, low
  input wire logic MODULE_SELECT_N_PIN, // Select pin; pulled-up level seen
  input wire logic MODULE_RESET_N, // Reset pin, low active
  input wire logic BUS_CMD_VALID, // Decoded serial command from bus engine
  input wire logic BUS_DATA_OE_REQ, // Bus engine wants to drive data low
  input wire logic BUS_ACK_REQ, // Bus engine wants to acknowledge
  input wire logic FAULT_EVENT, // Operational fault or critical status pulse
  input wire logic FLAGS_READ, // Host read the flag bytes (clears attention)
  output logic BUS_CMD_ACCEPT, // Command may be acted on
  output logic SDA_OUT, // Data line output value
  output logic SDA_OE, // Data line output enable, high drives
  output logic ATTENTION_N_OUT, // Attention pin output value
  output logic ATTENTION_N_OE, // Attention pin enable (open drain)
  output logic PRESENCE_N, // Presence output
  output logic DATA_NOT_READY, // Status bit, high during reset/init
  output logic SETTINGS_RESET // One-cycle pulse restoring user settings
);
  initial begin
    if (RST_MIN_CYC < 1 || INIT_CYC < 1 || POWERUP_CYC < 1) begin
      $error("mssr_top: cycle counts must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////
  logic sel_n_s;
  logic rst_n_s;

  // Reset value high: undriven select counts as unselected
  mssr_sync #(.RESET_VAL(1'b1)) u_sel_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin_in(MODULE_SELECT_N_PIN),
    .sync_out(sel_n_s)
  );

  mssr_sync #(.RESET_VAL(1'b1)) u_rst_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin_in(MODULE_RESET_N),
    .sync_out(rst_n_s)
  );

  ////////////////////////////////////////////////////////////////////
  mssr_state_e state_r;
  mssr_state_e state_nxt;
  logic [`MSSR_CNT_W-1:0] cnt_r;
  logic [`MSSR_CNT_W-1:0] cnt_nxt;
  logic [`MSSR_CNT_W-1:0] low_cnt_r;
  logic [`MSSR_CNT_W-1:0] low_cnt_nxt;
  logic dnr_r;
  logic dnr_nxt;
  logic att_r;
  logic att_nxt;
  logic settings_r;
  logic settings_nxt;
  logic reset_qual;

  // Low must last past minimum before reset is taken
  assign reset_qual = !rst_n_s && (low_cnt_r >= `MSSR_CNT_W'(RST_MIN_CYC));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dnr_nxt = dnr_r;
    att_nxt = att_r;
    settings_nxt = 1'b0;
    low_cnt_nxt = rst_n_s ? '0 : low_cnt_r + `MSSR_CNT_W'(1);
    if (!rst_n_s && low_cnt_r == '1) begin
      low_cnt_nxt = low_cnt_r;
    end
    if (FLAGS_READ) begin
      att_nxt = 1'b0;
    end
    if (FAULT_EVENT) begin
      att_nxt = 1'b1; // Set wins over clear
    end
    case (state_r)
      MSSR_POWERUP: begin
        dnr_nxt = 1'b1;
        if (cnt_r >= `MSSR_CNT_W'(POWERUP_CYC - 1)) begin
          state_nxt = MSSR_RUN;
          dnr_nxt = 1'b0;
          att_nxt = 1'b1; // Completion posted unprompted
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + `MSSR_CNT_W'(1);
        end
      end
      MSSR_RUN: begin
        if (reset_qual) begin
          state_nxt = MSSR_RESET;
          settings_nxt = 1'b1;
          dnr_nxt = 1'b1;
          att_nxt = 1'b0;
        end
      end
      MSSR_RESET: begin
        dnr_nxt = 1'b1;
        att_nxt = 1'b0;
        cnt_nxt = '0;
        if (rst_n_s) begin
          state_nxt = MSSR_INIT; // Init timed from rising edge
        end
      end
      MSSR_INIT: begin
        att_nxt = 1'b0;
        if (!rst_n_s) begin
          state_nxt = MSSR_RESET;
        end else if (cnt_r >= `MSSR_CNT_W'(INIT_CYC - 1)) begin
          state_nxt = MSSR_RUN;
          dnr_nxt = 1'b0;
          att_nxt = 1'b1; // Completion interrupt
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + `MSSR_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = MSSR_POWERUP;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_r <= MSSR_POWERUP;
      cnt_r <= '0;
      low_cnt_r <= '0;
      dnr_r <= 1'b1;
      att_r <= 1'b0;
      settings_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      dnr_r <= dnr_nxt;
      att_r <= att_nxt;
      settings_r <= settings_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  logic selected;
  assign selected = !sel_n_s && (state_r == MSSR_RUN);

  assign BUS_CMD_ACCEPT = selected && BUS_CMD_VALID;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = selected && (BUS_DATA_OE_REQ || BUS_ACK_REQ);
  assign ATTENTION_N_OUT = 1'b0;
  assign ATTENTION_N_OE = att_r;
  assign PRESENCE_N = 1'b0;
  assign DATA_NOT_READY = dnr_r;
  assign SETTINGS_RESET = settings_r;

  ////////////////////////////////////////////////////////////////////
  property p_cmd_gate;
    @(posedge CORE_CLK) disable iff (!RST_N)
      BUS_CMD_ACCEPT |-> !$past(MODULE_SELECT_N_PIN, 2) && state_r == MSSR_RUN
        && BUS_CMD_VALID;
  endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("command taken unselected");

  property p_no_drive;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $past(MODULE_SELECT_N_PIN, 2) |-> !SDA_OE && !BUS_CMD_ACCEPT;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven unselected");

  property p_sel_reset;
    @(posedge CORE_CLK) $rose(RST_N) |-> sel_n_s;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not high at reset");

  property p_settings;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == MSSR_RUN && reset_qual) |=> SETTINGS_RESET && state_r == MSSR_RESET;
  endproperty
  a_settings: assert property (p_settings) else $error("settings not restored");

  property p_short_pulse;
    @(posedge CORE_CLK) disable iff (!RST_N)
      SETTINGS_RESET |-> $past(low_cnt_r) >= `MSSR_CNT_W'(RST_MIN_CYC);
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse reset");

  property p_init_start;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r == MSSR_RESET && rst_n_s) |=> state_r == MSSR_INIT && cnt_r == '0;
  endproperty
  a_init_start: assert property (p_init_start) else $error("init not started");

  property p_complete;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state_r != MSSR_RUN ##1 state_r == MSSR_RUN) |-> ATTENTION_N_OE && !DATA_NOT_READY;
  endproperty
  a_complete: assert property (p_complete) else $error("no completion attention");

  property p_powerup;
    @(posedge CORE_CLK) $rose(RST_N) |-> state_r == MSSR_POWERUP && DATA_NOT_READY;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up not pending");

  property p_fault;
    @(posedge CORE_CLK) disable iff (!RST_N)
      FAULT_EVENT && (state_r == MSSR_POWERUP || (state_r == MSSR_RUN && !reset_qual))
        |=> ATTENTION_N_OE;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");

  property p_present;
    @(posedge CORE_CLK) !PRESENCE_N;
  endproperty
  a_present: assert property (p_present) else $error("presence not low");
endmodule // mssr_top

// ===== sim/mssr_host_model.sv
// Host board model: select pull-up, attention pull-up, status trust
`timescale 1ns/1ps
module mssr_host_model (
  input wire logic clk, // Core clock
  input wire logic sel_en, // Host drives select
  input wire logic sel_val, // Driven select level
  input wire logic rst_pin_n, // Reset pin level
  input wire logic attn_oe, // Module attention enable
  input wire logic dnr, // Data-not-ready bit
  output logic sel_pin_n, // Resolved select level
  output logic attn_pin_n, // Resolved attention level
  output logic status_ok // Status bits trusted
);
  assign sel_pin_n = sel_en ? sel_val : 1'b1;
  assign attn_pin_n = attn_oe ? 1'b0 : 1'b1;
  initial status_ok = 1'b0;
  always @(posedge clk) begin
    if (!rst_pin_n) status_ok <= 1'b0;
    else if (!attn_pin_n && !dnr) status_ok <= 1'b1;
  end
endmodule // mssr_host_model

// ===== sim/mssr_top_test.sv
// Testbench for the module sideband select and reset block
`timescale 1ns/1ps
module mssr_top_test;
  localparam int PWR = 20;
  localparam int INIT = 8;
  logic clk = 1'b0, rst_n = 1'b0, sel_en = 1'b0, sel_val = 1'b1, rst_val = 1'b1;
  logic cmd_v = 1'b0, oe_req = 1'b0, ack_req = 1'b0, fault = 1'b0, fread = 1'b0;
  logic sel_pin_n, attn_pin_n, status_ok;
  logic accept, sda_out, sda_oe, attn_out, attn_oe, pres_n, dnr, set_rst;
  int err_count = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  mssr_top #(.RST_MIN_CYC(4), .INIT_CYC(INIT), .POWERUP_CYC(PWR)) u_mssr_top (
    .CORE_CLK(clk), .RST_N(rst_n), .MODULE_SELECT_N_PIN(sel_pin_n),
    .MODULE_RESET_N(rst_val), .BUS_CMD_VALID(cmd_v), .BUS_DATA_OE_REQ(oe_req),
    .BUS_ACK_REQ(ack_req), .FAULT_EVENT(fault), .FLAGS_READ(fread),
    .BUS_CMD_ACCEPT(accept), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ATTENTION_N_OUT(attn_out), .ATTENTION_N_OE(attn_oe), .PRESENCE_N(pres_n),
    .DATA_NOT_READY(dnr), .SETTINGS_RESET(set_rst));
  mssr_host_model u_mssr_host_model (.clk(clk), .sel_en(sel_en), .sel_val(sel_val),
    .rst_pin_n(rst_val), .attn_oe(attn_oe), .dnr(dnr), .sel_pin_n(sel_pin_n),
    .attn_pin_n(attn_pin_n), .status_ok(status_ok));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for completion attention
  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim && !(attn_oe === 1'b1 && dnr === 1'b0); i++) cyc(1);
    chk("done_in_time", 1'b1, i < lim);
    cyc(1);
    chk("host_status", 1'b1, status_ok);
    chk("attn_pin", 1'b0, attn_pin_n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    chk("dnr_start", 1'b1, dnr);
    chk("attn_start", 1'b0, attn_oe);
    chk("presence", 1'b0, pres_n);
    chk("attn_out", 1'b0, attn_out);
    cyc(PWR - 2);
    chk("dnr_early", 1'b1, dnr);
    wait_done(10);
  endtask
  task automatic t_select();
    cmd_v = 1'b1;
    oe_req = 1'b1;
    ack_req = 1'b1;
    cyc(3);
    chk("accept_undriven", 1'b0, accept);
    chk("sda_oe_undriven", 1'b0, sda_oe);
    sel_en = 1'b1;
    cyc(3);
    chk("accept_high", 1'b0, accept);
    chk("sda_oe_high", 1'b0, sda_oe);
    sel_val = 1'b0;
    cyc(3);
    chk("accept_low", 1'b1, accept);
    chk("sda_oe_low", 1'b1, sda_oe);
    chk("sda_out", 1'b0, sda_out);
    cmd_v = 1'b0;
    oe_req = 1'b0;
    ack_req = 1'b0;
    cyc(1);
    chk("accept_idle", 1'b0, accept);
  endtask
  task automatic t_fault();
    fread = 1'b1;
    cyc(1);
    fread = 1'b0;
    cyc(1);
    chk("attn_cleared", 1'b0, attn_oe);
    fault = 1'b1;
    cyc(1);
    fault = 1'b0;
    cyc(1);
    chk("attn_fault", 1'b1, attn_oe);
    fread = 1'b1;
    cyc(1);
    fault = 1'b1;
    cyc(1);
    fread = 1'b0;
    fault = 1'b0;
    cyc(1);
    chk("attn_set_wins", 1'b1, attn_oe);
  endtask
  // Reset pin low for len cycles; taken says whether it qualifies
  task automatic t_reset(input int len, input logic taken);
    int seen = 0;
    cmd_v = 1'b1;
    rst_val = 1'b0;
    for (int i = 0; i < len + 3; i++) begin
      if (i == len) rst_val = 1'b1;
      cyc(1);
      if (set_rst === 1'b1) seen++;
    end
    chk("settings_reset", taken, seen == 1);
    chk("dnr_reset", taken, dnr);
    chk("attn_reset", !taken, attn_oe);
    chk("accept_reset", !taken, accept);
    if (taken) begin
      chk("host_status_busy", 1'b0, status_ok);
      cyc(INIT - 4);
      chk("dnr_init", 1'b1, dnr);
      wait_done(12);
    end
    cmd_v = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_powerup();
    t_select();
    t_fault();
    t_reset(3, 1'b0);
    t_reset(10, 1'b1);
    end_of_test();
  end
  initial begin
    #(20 * 2000);
    err_count++;
    end_of_test();
  end
endmodule // mssr_top_test
